// ==== reset_and_low_power_control.sv ====
// Purpose: Reset qualification, clock phases, idle, power-down and emulation entry.
// Assumes: Core hands over request bits with an instruction-done strobe.
// Notes: RAM and registers live in the core; this block only gates them.
`timescale 1ns/10ps
`default_nettype none
module reset_and_low_power_control
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Pins
   input wire logic reset_pin_i,
   input wire logic latch_strobe_i,
   input wire logic prog_store_strobe_i,
   input wire logic ext_irq_zero_i,
   input wire logic ext_irq_one_i,
   input wire logic supply_rise_i,
   // Core side
   input wire logic instr_done_i,
   input wire logic idle_req_i,
   input wire logic pdown_req_i,
   input wire logic irq_pending_i,
   input wire logic [1:0] irq_enable_i,
   input wire logic [1:0] irq_level_i,
   input wire logic pof_wr_i,
   input wire logic pof_wdata_i,
   // Clocking outputs
   output var logic osc_run_o,
   output var logic phase_en_o,
   output var logic mcycle_en_o,
   output var logic core_run_o,
   output var logic periph_run_o,
   // Reset and mode outputs
   output var logic core_reset_o,
   output var logic port_reset_o,
   output var lowpwr_pkg::mode_t mode_o,
   output var logic idle_bit_o,
   output var logic pdown_bit_o,
   output var logic wake_irq_o,
   output var logic ram_block_o,
   output var logic power_off_flag_o,
   // Emulation outputs
   output var logic emulation_o,
   output var logic port0_float_o,
   output var logic weak_pull_o
);
   import lowpwr_pkg::*;

   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic pin_s;
   logic irq0_s;
   logic irq1_s;
   logic latch_s;
   logic prog_s;
   logic supply_s;
   logic osc_run_q;
   logic phase_q;
   logic [3:0] mc_cnt_q;
   logic mcycle_q;
   logic [4:0] qual_cnt_q;
   logic core_reset_q;
   logic port_reset_q;
   mode_t mode_q;
   logic wake_q;
   logic ram_block_q;
   logic pof_q;
   logic arm_q;
   logic emu_q;
   logic core_run_q;
   logic periph_run_q;
   logic [1:0] irq_wake_ok;
   logic wake_low;
   logic take_req;

   // Two-stage synchroniser for every pin
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_q <= SYNC_RESET;
         sync_q <= SYNC_RESET;
      end
      else
      begin
         meta_q <= {supply_rise_i, prog_store_strobe_i, latch_strobe_i,
                    ext_irq_one_i, ext_irq_zero_i, reset_pin_i};
         sync_q <= meta_q;
      end
   end

   assign pin_s = sync_q[0];
   assign irq0_s = sync_q[1];
   assign irq1_s = sync_q[2];
   assign latch_s = sync_q[3];
   assign prog_s = sync_q[4];
   assign supply_s = sync_q[5];

   // Only lines set up as enabled and level-sensitive may wake power-down
   assign irq_wake_ok = irq_enable_i & irq_level_i;
   assign wake_low = |(irq_wake_ok & ~{irq1_s, irq0_s});
   // Requests are taken only when the requesting instruction has completed
   assign take_req = instr_done_i && !core_reset_q && !emu_q;

   // Oscillator gate; power-down stops it, reset or a low wake line restarts it
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         osc_run_q <= OSC_RUN_RESET;
      else if (pin_s || wake_low || emu_q)
         osc_run_q <= 1'b1;
      else if (mode_q == MODE_RUN && take_req && pdown_req_i)
         osc_run_q <= 1'b0;
   end

   // Divide-by-two phase, so internal timing ignores input duty cycle
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         phase_q <= 1'b0;
      else if (osc_run_q)
         phase_q <= ~phase_q;
   end

   // Machine cycle tick every twelve oscillator periods; frozen while stopped
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mc_cnt_q <= 4'h0;
         mcycle_q <= 1'b0;
      end
      else if (osc_run_q)
      begin
         mcycle_q <= (mc_cnt_q == 4'(OSC_PER_MCYCLE - 1));
         mc_cnt_q <= (mc_cnt_q == 4'(OSC_PER_MCYCLE - 1)) ? 4'h0 : mc_cnt_q + 4'h1;
      end
      else
         mcycle_q <= 1'b0;
   end

   // Reset qualification: two machine cycles of pin high with oscillator running
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         qual_cnt_q <= 5'h00;
         core_reset_q <= 1'b0;
      end
      else if (!pin_s)
      begin
         qual_cnt_q <= 5'h00;
         core_reset_q <= 1'b0;
      end
      else if (osc_run_q && !core_reset_q)
      begin
         qual_cnt_q <= qual_cnt_q + 5'h01;
         core_reset_q <= (qual_cnt_q == 5'(RESET_QUAL_OSC - 1));
      end
   end

   // Ports follow the raw pin with no clock, then the qualified reset
   always_ff @(posedge clock_i or posedge rst_i or posedge reset_pin_i)
   begin
      if (rst_i || reset_pin_i)
         port_reset_q <= 1'b1;
      else
         port_reset_q <= pin_s || core_reset_q;
   end

   // Mode sequencer; the active request bit clears on every exit
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_q <= MODE_RUN;
         wake_q <= 1'b0;
      end
      else
      begin
         wake_q <= 1'b0;
         if (core_reset_q)
            mode_q <= MODE_RUN;
         else
         begin
            case (mode_q)
               MODE_RUN:
               begin
                  if (take_req && pdown_req_i)
                     mode_q <= MODE_PDOWN;
                  else if (take_req && idle_req_i)
                     mode_q <= MODE_IDLE;
               end
               MODE_IDLE:
               begin
                  // Reset lets the core run until qualification takes over
                  if (pin_s)
                     mode_q <= MODE_RUN;
                  else if (irq_pending_i)
                  begin
                     mode_q <= MODE_RUN;
                     wake_q <= 1'b1;
                  end
               end
               MODE_PDOWN:
               begin
                  if (pin_s)
                     mode_q <= MODE_RUN;
                  else if (wake_low)
                     mode_q <= MODE_WAKE;
               end
               MODE_WAKE:
               begin
                  // No reset here, so registers and RAM hold their values
                  if (pin_s)
                     mode_q <= MODE_RUN;
                  else if (!wake_low)
                  begin
                     mode_q <= MODE_RUN;
                     wake_q <= 1'b1;
                  end
               end
               default:
                  mode_q <= MODE_RUN;
            endcase
         end
      end
   end

   // Core and peripheral run enables; peripherals keep going in idle
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         core_run_q <= 1'b0;
         periph_run_q <= 1'b0;
      end
      else
      begin
         core_run_q <= osc_run_q && mode_q == MODE_RUN && !core_reset_q && !emu_q;
         periph_run_q <= osc_run_q && (mode_q == MODE_RUN || mode_q == MODE_IDLE);
      end
   end

   // RAM blocked while a reset that ended idle is still being qualified
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         ram_block_q <= 1'b0;
      else if (core_reset_q || !pin_s)
         ram_block_q <= 1'b0;
      else if (mode_q == MODE_IDLE)
         ram_block_q <= 1'b1;
   end

   // Power-off flag; a supply rise wins over a software write
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         pof_q <= POF_RESET;
      else if (supply_s)
         pof_q <= 1'b1;
      else if (pof_wr_i)
         pof_q <= pof_wdata_i;
   end

   // Emulation strap: armed in reset, caught as the reset is released
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         arm_q <= 1'b0;
         emu_q <= 1'b0;
      end
      else if (core_reset_q)
      begin
         arm_q <= !latch_s && prog_s;
         if (!pin_s)
            emu_q <= arm_q && !latch_s;
         else
            emu_q <= 1'b0;
      end
   end

   assign osc_run_o = osc_run_q;
   assign phase_en_o = phase_q;
   assign mcycle_en_o = mcycle_q;
   assign core_run_o = core_run_q;
   assign periph_run_o = periph_run_q;
   assign core_reset_o = core_reset_q;
   assign port_reset_o = port_reset_q;
   assign mode_o = mode_q;
   assign idle_bit_o = (mode_q == MODE_IDLE);
   assign pdown_bit_o = (mode_q == MODE_PDOWN || mode_q == MODE_WAKE);
   assign wake_irq_o = wake_q;
   assign ram_block_o = ram_block_q;
   assign power_off_flag_o = pof_q;
   assign emulation_o = emu_q;
   // Port 0 floats, other pins and strobes pulled weakly high
   assign port0_float_o = emu_q;
   assign weak_pull_o = emu_q;

   // Checks
   qual_time_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(core_reset_q) |-> $past(qual_cnt_q) == 5'(RESET_QUAL_OSC - 1) && $past(pin_s))
      else $error("reset taken without full qualification");
   port_force_a: assert property (@(posedge clock_i) disable iff (rst_i)
      pin_s |-> port_reset_q)
      else $error("ports not held in reset");
   phase_flip_a: assert property (@(posedge clock_i) disable iff (rst_i)
      osc_run_q |=> phase_q != $past(phase_q))
      else $error("phase did not toggle");
   mcycle_gap_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mcycle_q |=> !mcycle_q[*8])
      else $error("machine cycle too short");
   idle_run_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mode_q == MODE_IDLE && osc_run_q |=> !core_run_q && periph_run_q)
      else $error("idle enables wrong");
   idle_enter_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mode_q == MODE_RUN && take_req && idle_req_i && !pdown_req_i |=> mode_q == MODE_IDLE)
      else $error("idle not entered");
   pdown_osc_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mode_q == MODE_PDOWN |-> !osc_run_q)
      else $error("oscillator runs in power-down");
   ram_window_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(ram_block_q) |-> ##[0:24] core_reset_q)
      else $error("idle reset window too long");
   wake_done_a: assert property (@(posedge clock_i) disable iff (rst_i)
      mode_q == MODE_WAKE && !wake_low && !pin_s |=> mode_q == MODE_RUN && wake_q)
      else $error("wake not completed");
   pof_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      supply_s |=> pof_q)
      else $error("power-off flag not set");
   emu_exit_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $fell(emu_q) |-> $past(core_reset_q))
      else $error("emulation left without reset");

endmodule : reset_and_low_power_control
`default_nettype wire

// ==== lowpwr_pkg.sv ====
// Purpose: Constants and types for reset and low-power sequencing.
// Assumes: clock_i is the oscillator at 50 MHz.
// Notes: Notes on behaviour follow.
// Notes on behaviour
// - Reset taken only after pin high 24 oscillator periods, oscillator running.
// - Reset pin forces ports one to three to reset state without a clock.
// - Internal timing comes from a divide-by-two stage, not input duty cycle.
// - Fully static; clock may stop and all state is kept.
// - Idle stops the core, peripherals keep running, state kept.
// - The idle request instruction completes and is the last one executed.
// - Idle ends on enabled interrupt or on hardware reset.
// - Power-down stops the oscillator after the requesting instruction completes.
// - Reset out of power-down reinitialises registers, keeps RAM.
// - Interrupt out of power-down keeps registers and RAM.
// - Interrupt wake only with external lines enabled and level-sensitive.
// - Line low restarts the oscillator; line high completes the exit.
// - After return from interrupt, execution follows the power-down instruction.
// - Power-off flag set on supply rise; software may set or clear it.
// - Reset ending idle lets the core run up to two machine cycles.
// - During that window internal RAM is blocked, port pins are not.
// - Emulation entered with latch strobe low in reset, program strobe high.
// - Emulation floats port 0, weakly pulls others high, oscillator runs.
// - Emulation left only by an ordinary reset.
`default_nettype none
package lowpwr_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned OSC_PER_MCYCLE = 12;
   localparam int unsigned RESET_MCYCLES = 2;
   localparam int unsigned RESET_QUAL_OSC = OSC_PER_MCYCLE * RESET_MCYCLES;
   // Synchroniser order: supply, prog strobe, latch strobe, irq one, irq zero, reset pin
   localparam logic [5:0] SYNC_RESET = 6'h1e;
   localparam logic POF_RESET = 1'b0;
   localparam logic OSC_RUN_RESET = 1'b1;
   typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_PDOWN, MODE_WAKE} mode_t;
endpackage : lowpwr_pkg
`default_nettype wire

// ==== board_model.sv ====
// Purpose: Board-side model of reset source, interrupt pins, supply detect and emulator strobes.
// Assumes: Pins change only after a falling clock edge.
// Notes: The bench steers it through its tasks; the pins idle at their inactive levels.
`timescale 1ns/10ps
`default_nettype none
module board_model
(
   // Clock
   input wire logic clock_i,
   // Pins towards the device
   output var logic reset_pin_o,
   output var logic latch_strobe_o,
   output var logic prog_store_strobe_o,
   output var logic ext_irq_zero_o,
   output var logic ext_irq_one_o,
   output var logic supply_rise_o
);
   // Inactive levels at power-up; strobes are pulled high
   initial
   begin
      reset_pin_o = 1'b0;
      latch_strobe_o = 1'b1;
      prog_store_strobe_o = 1'b1;
      ext_irq_zero_o = 1'b1;
      ext_irq_one_o = 1'b1;
      supply_rise_o = 1'b0;
   end

   // Caller holds the level long enough for qualification and oscillator restart
   task set_reset(input logic v);
      @(negedge clock_i);
      reset_pin_o = v;
   endtask : set_reset

   // Latch strobe low with program strobe high selects emulation
   task set_latch(input logic v);
      @(negedge clock_i);
      latch_strobe_o = v;
   endtask : set_latch

   // Program strobe level seen by the emulation strap
   task set_prog(input logic v);
      @(negedge clock_i);
      prog_store_strobe_o = v;
   endtask : set_prog

   // Low restarts the oscillator, high finishes the wake
   task set_irq(input logic [1:0] v);
      @(negedge clock_i);
      ext_irq_zero_o = v[0];
      ext_irq_one_o = v[1];
   endtask : set_irq

   // Supply rising from zero
   task set_supply(input logic v);
      @(negedge clock_i);
      supply_rise_o = v;
   endtask : set_supply
endmodule : board_model
`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for reset and low-power sequencing.
// Assumes: Core-side inputs change on the falling edge.
// Notes: Waits are bounded so a stuck mode cannot hang the run.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import lowpwr_pkg::*;
   logic clock_i, rst_i;
   logic rp, ls, ps, iz, io, sr;
   logic instr_done_i, idle_req_i, pdown_req_i, irq_pending_i;
   logic [1:0] irq_enable_i, irq_level_i;
   logic pof_wr_i, pof_wdata_i;
   logic osc_run_o, phase_en_o, mcycle_en_o, core_run_o, periph_run_o, core_reset_o, port_reset_o;
   logic idle_bit_o, pdown_bit_o, wake_irq_o, ram_block_o, power_off_flag_o;
   logic emulation_o, port0_float_o, weak_pull_o;
   mode_t mode_o;
   int miscompares = 0, num_checks = 0;

   board_model u_board_model (.clock_i(clock_i), .reset_pin_o(rp), .latch_strobe_o(ls),
      .prog_store_strobe_o(ps), .ext_irq_zero_o(iz), .ext_irq_one_o(io), .supply_rise_o(sr));
   reset_and_low_power_control u_reset_and_low_power_control (.clock_i(clock_i), .rst_i(rst_i),
      .reset_pin_i(rp), .latch_strobe_i(ls), .prog_store_strobe_i(ps), .ext_irq_zero_i(iz),
      .ext_irq_one_i(io), .supply_rise_i(sr), .instr_done_i(instr_done_i), .idle_req_i(idle_req_i),
      .pdown_req_i(pdown_req_i), .irq_pending_i(irq_pending_i), .irq_enable_i(irq_enable_i),
      .irq_level_i(irq_level_i), .pof_wr_i(pof_wr_i), .pof_wdata_i(pof_wdata_i),
      .osc_run_o(osc_run_o), .phase_en_o(phase_en_o), .mcycle_en_o(mcycle_en_o),
      .core_run_o(core_run_o), .periph_run_o(periph_run_o), .core_reset_o(core_reset_o),
      .port_reset_o(port_reset_o), .mode_o(mode_o), .idle_bit_o(idle_bit_o),
      .pdown_bit_o(pdown_bit_o), .wake_irq_o(wake_irq_o), .ram_block_o(ram_block_o),
      .power_off_flag_o(power_off_flag_o), .emulation_o(emulation_o),
      .port0_float_o(port0_float_o), .weak_pull_o(weak_pull_o));

   // 50 MHz clock
   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   task check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask : check_bit

   task check_mode(input mode_t exp);
      num_checks++;
      if (mode_o !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: mode got %0d expected %0d", $time, mode_o, exp);
      end
   endtask : check_mode

   task cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   // Bounded wait on a design signal: 0 core reset, 1 wake pulse, 2 oscillator
   task wait_sig(input int sel, input int n);
      logic s;
      for (int i = 0; i < n; i++)
      begin
         @(negedge clock_i);
         s = (sel == 0) ? core_reset_o : (sel == 1) ? wake_irq_o : osc_run_o;
         if (s === 1'b1)
            break;
      end
      check_bit(s, 1'b1);
   endtask : wait_sig

   // One instruction completes carrying the request bits
   task req(input logic idl, input logic pd);
      @(negedge clock_i);
      instr_done_i = 1'b1;
      idle_req_i = idl;
      pdown_req_i = pd;
      @(negedge clock_i);
      instr_done_i = 1'b0;
      idle_req_i = 1'b0;
      pdown_req_i = 1'b0;
   endtask : req

   // Full qualified reset pulse, then release
   task full_reset;
      u_board_model.set_reset(1'b1);
      wait_sig(0, 40);
      u_board_model.set_reset(1'b0);
      cyc(4);
   endtask : full_reset

   task t_reset_qual;
      u_board_model.set_reset(1'b1);
      #1 check_bit(port_reset_o, 1'b1);
      cyc(10);
      check_bit(core_reset_o, 1'b0);
      u_board_model.set_reset(1'b0);
      cyc(4);
      check_bit(port_reset_o, 1'b0);
      u_board_model.set_reset(1'b1);
      cyc(23);
      check_bit(core_reset_o, 1'b0);
      cyc(5);
      check_bit(core_reset_o, 1'b1);
      u_board_model.set_reset(1'b0);
      cyc(4);
      check_bit(core_reset_o, 1'b0);
      $display("test reset qualification done");
   endtask : t_reset_qual

   // Phase flips every clock; machine cycle pulse every twelve clocks
   task t_clocking;
      logic p;
      p = phase_en_o;
      cyc(1);
      check_bit(phase_en_o, ~p);
      for (int i = 0; i < 13 && mcycle_en_o !== 1'b1; i++)
         cyc(1);
      check_bit(mcycle_en_o, 1'b1);
      cyc(11);
      check_bit(mcycle_en_o, 1'b0);
      cyc(1);
      check_bit(mcycle_en_o, 1'b1);
      $display("test clocking done");
   endtask : t_clocking

   task t_idle_irq;
      req(1'b1, 1'b0);
      cyc(2);
      check_mode(MODE_IDLE);
      check_bit(core_run_o, 1'b0);
      check_bit(periph_run_o, 1'b1);
      check_bit(idle_bit_o, 1'b1);
      irq_pending_i = 1'b1;
      wait_sig(1, 4);
      irq_pending_i = 1'b0;
      cyc(1);
      check_bit(idle_bit_o, 1'b0);
      check_bit(core_run_o, 1'b1);
      $display("test idle interrupt done");
   endtask : t_idle_irq

   task t_pdown_irq;
      irq_enable_i = 2'h3;
      irq_level_i = 2'h3;
      req(1'b1, 1'b1);
      cyc(2);
      check_mode(MODE_PDOWN);
      check_bit(osc_run_o, 1'b0);
      u_board_model.set_irq(2'h2);
      wait_sig(2, 6);
      check_mode(MODE_WAKE);
      u_board_model.set_irq(2'h3);
      wait_sig(1, 6);
      cyc(1);
      check_mode(MODE_RUN);
      check_bit(pdown_bit_o, 1'b0);
      check_bit(core_reset_o, 1'b0);
      $display("test power-down interrupt done");
   endtask : t_pdown_irq

   task t_pdown_reset;
      irq_level_i = 2'h0;
      req(1'b0, 1'b1);
      u_board_model.set_irq(2'h0);
      cyc(6);
      check_bit(osc_run_o, 1'b0);
      check_mode(MODE_PDOWN);
      u_board_model.set_irq(2'h3);
      full_reset();
      check_bit(osc_run_o, 1'b1);
      check_mode(MODE_RUN);
      $display("test power-down reset done");
   endtask : t_pdown_reset

   task t_idle_reset;
      req(1'b1, 1'b0);
      cyc(2);
      u_board_model.set_reset(1'b1);
      cyc(4);
      check_bit(ram_block_o, 1'b1);
      check_bit(core_run_o, 1'b1);
      check_mode(MODE_RUN);
      wait_sig(0, 30);
      cyc(1);
      check_bit(ram_block_o, 1'b0);
      u_board_model.set_reset(1'b0);
      cyc(4);
      $display("test idle reset done");
   endtask : t_idle_reset

   task t_pof;
      u_board_model.set_supply(1'b1);
      cyc(4);
      check_bit(power_off_flag_o, 1'b1);
      pof_wdata_i = 1'b0;
      pof_wr_i = 1'b1;
      cyc(1);
      pof_wr_i = 1'b0;
      cyc(1);
      check_bit(power_off_flag_o, 1'b1);
      u_board_model.set_supply(1'b0);
      cyc(3);
      pof_wr_i = 1'b1;
      cyc(1);
      pof_wr_i = 1'b0;
      cyc(1);
      check_bit(power_off_flag_o, 1'b0);
      pof_wdata_i = 1'b1;
      pof_wr_i = 1'b1;
      cyc(1);
      pof_wr_i = 1'b0;
      cyc(1);
      check_bit(power_off_flag_o, 1'b1);
      $display("test power-off flag done");
   endtask : t_pof

   task t_emulation;
      u_board_model.set_prog(1'b0);
      u_board_model.set_reset(1'b1);
      wait_sig(0, 40);
      u_board_model.set_latch(1'b0);
      cyc(3);
      u_board_model.set_reset(1'b0);
      cyc(4);
      check_bit(emulation_o, 1'b0);
      u_board_model.set_latch(1'b1);
      u_board_model.set_prog(1'b1);
      cyc(2);
      u_board_model.set_reset(1'b1);
      wait_sig(0, 40);
      u_board_model.set_latch(1'b0);
      cyc(3);
      u_board_model.set_reset(1'b0);
      cyc(4);
      u_board_model.set_latch(1'b1);
      cyc(1);
      check_bit(emulation_o, 1'b1);
      check_bit(port0_float_o, 1'b1);
      check_bit(weak_pull_o, 1'b1);
      check_bit(osc_run_o, 1'b1);
      req(1'b1, 1'b0);
      cyc(2);
      check_mode(MODE_RUN);
      full_reset();
      check_bit(emulation_o, 1'b0);
      $display("test emulation done");
   endtask : t_emulation

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   // Main sequence
   initial
   begin
      rst_i = 1'b1;
      instr_done_i = 1'b0;
      idle_req_i = 1'b0;
      pdown_req_i = 1'b0;
      irq_pending_i = 1'b0;
      irq_enable_i = 2'h0;
      irq_level_i = 2'h0;
      pof_wr_i = 1'b0;
      pof_wdata_i = 1'b0;
      cyc(6);
      rst_i = 1'b0;
      cyc(2);
      t_reset_qual();
      t_clocking();
      t_idle_irq();
      t_pdown_irq();
      t_pdown_reset();
      t_idle_reset();
      t_pof();
      t_emulation();
      conclude();
   end

   // Watchdog well beyond the expected few hundred cycles
   initial
   begin
      #100000;
      miscompares++;
      conclude();
   end
endmodule : tb_top
`default_nettype wire
